// [bench/spc2_line_model.sv]
// Remote transceiver on the serial line: wire level, frame capture, longest low run
`timescale 1ns/1ps
`default_nettype none
module spc2_line_model #(
    parameter int BC = 4
) (
    input  wire logic       mclk,
    input  wire logic       pin_out,
    input  wire logic       pin_oe,
    input  wire logic       drv_en,
    input  wire logic       drv_val,
    input  wire logic       clr,
    output logic            wire_lvl,
    output logic [9:0]      frame,
    output int              low_run
);
    int low_cnt = 0;
    logic hi_prev = 1'b1;
    // Pull-up keeps a released line high
    assign wire_lvl = pin_oe ? pin_out : (drv_en ? drv_val : 1'b1);
    always @(posedge mclk) begin
        // A high shorter than two cycles is far below a bit time and does not end a low run
        low_cnt = wire_lvl ? (hi_prev ? 0 : low_cnt) : low_cnt + 1;
        hi_prev = wire_lvl;
        if (clr)
            low_run = 0;
        else if (low_cnt > low_run)
            low_run = low_cnt;
    end
    // The first short start bit hides the bit grid, so bit 0 of the data must be 1
    initial begin : capture
        frame = 10'h000;
        forever begin
            @(posedge mclk iff !wire_lvl);
            @(posedge mclk iff wire_lvl);
            repeat (BC / 2) @(posedge mclk);
            for (int i = 0; i < 10; i++) begin
                frame[i] = wire_lvl;
                repeat (BC) @(posedge mclk);
            end
        end
    end
endmodule : spc2_line_model
`default_nettype wire

// [bench/spc2_top_assertions.sv]
// Port-level checker for the serial port second control block
`timescale 1ns/1ps
`default_nettype none
module spc2_top_assertions (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       rx_buf_full,
    input wire logic       line_quiet_flag,
    input wire logic       wake_idle_seen,
    input wire logic       wake_mark_seen,
    input wire logic       serial_out_pin_oe,
    input wire logic       rx_pin_owned,
    input wire logic       rx_line,
    input wire logic       rx_enabled,
    input wire logic       rx_standby,
    input wire logic       irq
);
    logic [7:0] sh_ctrl, sh_cfg, next_sh_ctrl, next_sh_cfg;
    logic       sw_in, wk;
    // Shadow of what software last wrote
    always_comb begin
        next_sh_ctrl = sh_ctrl;
        next_sh_cfg = sh_cfg;
        if (reg_wr && reg_addr == 2'h0) next_sh_ctrl = reg_wdata;
        if (reg_wr && reg_addr == 2'h1) next_sh_cfg = reg_wdata;
    end
    always_ff @(posedge mclk) begin
        sh_ctrl <= rstn ? next_sh_ctrl : 8'h00;
        sh_cfg <= rstn ? next_sh_cfg : 8'h00;
    end
    assign sw_in = sh_cfg[7] && sh_cfg[5] && !sh_cfg[1];
    assign wk = sh_cfg[3] ? wake_mark_seen : wake_idle_seen;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence quiet;
        (!reg_wr) [*3];
    endsequence
    rd_data_gap_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    irq_masked_a: assert property (quiet ##0 sh_ctrl[7:4] == 4'h0 |-> !irq)
        else $error("irq with all enables off");
    irq_rx_full_a: assert property (
        quiet ##0 (sh_ctrl[5] && rx_buf_full && $past(rx_buf_full)) |-> irq)
        else $error("no irq for enabled full flag");
    tx_pin_own_a: assert property (quiet ##0 (sh_ctrl[3] && !sw_in) |-> serial_out_pin_oe)
        else $error("tx on but pin not driven");
    single_dir_a: assert property (quiet ##0 sw_in |-> !serial_out_pin_oe)
        else $error("pin driven in single-wire input");
    rx_pin_rel_a: assert property (
        quiet |-> rx_pin_owned == (sh_ctrl[2] && !sh_cfg[7]) && rx_enabled == sh_ctrl[2])
        else $error("input pin ownership wrong");
    rx_line_idle_a: assert property (quiet ##0 !sh_cfg[7] |-> rx_line)
        else $error("receiver line low outside loopback");
    wake_clear_a: assert property (
        quiet ##0 (rx_standby && rx_enabled && wk) |-> ##[1:2] !rx_standby)
        else $error("standby not cleared by wakeup");
    wake_hold_a: assert property (
        (rx_standby && !wk && !reg_wr) [*3] ##1 (!wk && !reg_wr) |-> rx_standby)
        else $error("standby left without wakeup");
    reset_idle_a: assert property (disable iff (1'b0)
        !rstn |=> !serial_out_pin_oe && !irq && !rx_standby && reg_rdata == 8'h00)
        else $error("outputs not idle after reset");
    cover property (serial_out_pin_oe ##1 !serial_out_pin_oe);
    cover property (rx_standby ##1 !rx_standby);
    cover property (!irq ##1 irq);
endmodule : spc2_top_assertions
bind spc2_top spc2_top_assertions u_chk (
    .mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_buf_full,
    .line_quiet_flag, .wake_idle_seen, .wake_mark_seen, .serial_out_pin_oe, .rx_pin_owned,
    .rx_line, .rx_enabled, .rx_standby, .irq
);
`default_nettype wire

// [bench/spc2_top_tb_top.sv]
// Self-checking bench for the serial port second control block
`timescale 1ns/1ps
`default_nettype none
module spc2_top_tb_top;
    localparam int BC = 4;
    logic       mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clr = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
    logic       rx_buf_full = 1'b0, line_quiet_flag = 1'b0, drv_en = 1'b0, drv_val = 1'b0;
    logic       wake_idle_seen = 1'b0, wake_mark_seen = 1'b0;
    logic       pin_out, pin_oe, pin_wire, rx_pin_owned, rx_line, rx_enabled, rx_standby, irq;
    logic [9:0] frame;
    int         low_run, cnt, bad_count = 0, checked = 0;
    always #2.5 mclk = ~mclk;
    spc2_top #(.BIT_CYCLES(BC)) DUT (
        .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_buf_full(rx_buf_full),
        .line_quiet_flag(line_quiet_flag), .wake_idle_seen(wake_idle_seen),
        .wake_mark_seen(wake_mark_seen), .serial_out_pin_in(pin_wire),
        .serial_out_pin_out(pin_out), .serial_out_pin_oe(pin_oe), .rx_pin_owned(rx_pin_owned),
        .rx_line(rx_line), .rx_enabled(rx_enabled), .rx_standby(rx_standby), .irq(irq)
    );
    spc2_line_model #(.BC(BC)) u_line (
        .mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .drv_en(drv_en), .drv_val(drv_val),
        .clr(clr), .wire_lvl(pin_wire), .frame(frame), .low_run(low_run)
    );
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [1:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        d = reg_rdata;
    endtask : rd
    task automatic wake(input logic m);
        wake_mark_seen <= m;
        wake_idle_seen <= !m;
        @(posedge mclk);
        wake_mark_seen <= 1'b0;
        wake_idle_seen <= 1'b0;
        cyc(3);
    endtask : wake
    task automatic t_regs;
        rd(2'h2);
        chk("status", 8'hC0, d);
        wr(2'h1, 8'h5A);
        wr(2'h0, 8'h30);
        wr(2'h2, 8'hFF);
        rd(2'h1);
        chk("cfg", 8'h5A, d);
        rd(2'h0);
        chk("ctrl2", 8'h30, d);
        wr(2'h1, 8'h00);
        $display("done: registers");
    endtask : t_regs
    task automatic t_irq;
        for (int f = 0; f < 2; f++) begin
            rx_buf_full <= f[0];
            line_quiet_flag <= f[0];
            for (int i = 4; i < 8; i++) begin
                wr(2'h0, 8'h01 << i);
                cyc(3);
                chk("irq", (i > 5) ? 1'b1 : f[0], irq);
            end
        end
        wr(2'h0, 8'h00);
        cyc(3);
        chk("irq masked", 1'b0, irq);
        rx_buf_full <= 1'b0;
        line_quiet_flag <= 1'b0;
        $display("done: interrupts");
    endtask : t_irq
    task automatic t_frames;
        wr(2'h0, 8'h08);
        cyc(12 * BC);
        chk("tx oe", 1'b1, pin_oe);
        wr(2'h3, 8'hA3);
        cyc(16 * BC);
        chk("frame 8 bit", 10'h3A3, frame);
        wr(2'h1, 8'h10);
        wr(2'h3, 8'h5B);
        cyc(16 * BC);
        chk("frame 9 bit", 10'h25B, frame);
        $display("done: frames");
    endtask : t_frames
    task automatic t_break;
        int n;
        for (int k = 0; k < 2; k++) begin
            n = k ? 13 : 10;
            wr(2'h1, k ? 8'h04 : 8'h00);
            clr <= 1'b1;
            cyc(1);
            clr <= 1'b0;
            wr(2'h0, 8'h09);
            wr(2'h0, 8'h08);
            cyc(4 * n * BC);
            chk("one break", 1'b1, (low_run > (n - 1) * BC && low_run <= n * BC) ||
                (low_run >= (2 * n - 1) * BC && low_run <= 2 * n * BC));
            clr <= 1'b1;
            wr(2'h0, 8'h09);
            clr <= 1'b0;
            cyc((3 * n + 1) * BC);
            wr(2'h0, 8'h08);
            cyc(4 * n * BC);
            chk("held break", 1'b1, low_run >= 3 * n * BC);
        end
        wr(2'h1, 8'h00);
        $display("done: breaks");
    endtask : t_break
    task automatic t_owner;
        wr(2'h3, 8'hA5);
        wr(2'h0, 8'h00);
        wr(2'h0, 8'h08);
        wr(2'h0, 8'h00);
        cnt = 0;
        while (pin_oe === 1'b1 && cnt < 40 * BC) begin
            @(posedge mclk);
            cnt++;
        end
        chk("owned span", 1'b1, cnt > 14 * BC && cnt <= 22 * BC);
        $display("done: pin ownership");
    endtask : t_owner
    task automatic t_pins;
        wr(2'h0, 8'h04);
        cyc(3);
        chk("rx owned", 1'b1, rx_pin_owned);
        chk("rx line", 1'b1, rx_line);
        wr(2'h1, 8'hA0);
        wr(2'h0, 8'h0C);
        drv_en <= 1'b1;
        cyc(3);
        chk("rx released", 1'b0, rx_pin_owned);
        chk("oe input dir", 1'b0, pin_oe);
        chk("rx from wire", 1'b0, rx_line);
        drv_en <= 1'b0;
        wr(2'h1, 8'hA2);
        cyc(3);
        chk("oe output dir", 1'b1, pin_oe);
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h00);
        cyc(12 * BC);
        chk("rx off", 1'b0, rx_pin_owned);
        $display("done: pins");
    endtask : t_pins
    task automatic t_standby;
        for (int s = 0; s < 2; s++) begin
            wr(2'h1, s ? 8'h08 : 8'h00);
            wr(2'h0, 8'h06);
            cyc(3);
            chk("standby set", 1'b1, rx_standby);
            wake(!s[0]);
            chk("standby kept", 1'b1, rx_standby);
            wake(s[0]);
            chk("standby woke", 1'b0, rx_standby);
        end
        wr(2'h0, 8'h2C);
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
        cyc(1);
        rd(2'h0);
        chk("ctrl2 reset", 8'h00, d);
        $display("done: standby and reset");
    endtask : t_standby
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        clr <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_irq();
        t_frames();
        t_break();
        t_owner();
        t_pins();
        t_standby();
        report_and_stop();
    end
    initial begin
        repeat (12000) @(posedge mclk);
        bad_count++;
        report_and_stop();
    end
endmodule : spc2_top_tb_top
`default_nettype wire

// [core/spc2_params.svh]
// Offsets, field positions, reset values and timing counts of the serial port control block
`ifndef SPC2_PARAMS_SVH
`define SPC2_PARAMS_SVH

`define SPC2_OFS_CTRL2        2'h0
`define SPC2_OFS_CFG          2'h1
`define SPC2_OFS_STATUS       2'h2
`define SPC2_OFS_TXDATA       2'h3

`define SPC2_CTRL2_RESET      8'h00
`define SPC2_CFG_RESET        8'h00

`define SPC2_BIT_TX_EMPTY_IE  7
`define SPC2_BIT_TX_DONE_IE   6
`define SPC2_BIT_RX_FULL_IE   5
`define SPC2_BIT_QUIET_IE     4
`define SPC2_BIT_TX_ON        3
`define SPC2_BIT_RX_ON        2
`define SPC2_BIT_RX_STANDBY   1
`define SPC2_BIT_BREAK_QUEUE  0

`define SPC2_CLK_MHZ          200
`define SPC2_BIT_TIME_NS      80
`define SPC2_BIT_CYCLES       ((`SPC2_BIT_TIME_NS * `SPC2_CLK_MHZ) / 1000)

`define SPC2_LEN_SHORT        4'hA
`define SPC2_LEN_SHORT9       4'hB
`define SPC2_LEN_LONG         4'hD
`define SPC2_LEN_LONG9        4'hE

`endif

// [core/spc2_pkg.sv]
// Types shared by the serial port control block
package spc2_pkg;

    typedef struct packed {
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_full_irq_en;
        logic line_quiet_irq_en;
        logic tx_on;
        logic rx_on;
        logic rx_standby;
        logic break_queue;
    } spc2_ctrl_s;

    typedef struct packed {
        logic loopback_sel;
        logic tx_bit8;
        logic rx_source_sel;
        logic nine_bit_sel;
        logic wake_sel;
        logic long_break_sel;
        logic single_line_dir;
        logic spare;
    } spc2_cfg_s;

    typedef struct packed {
        logic tx_buf_empty;
        logic tx_done;
        logic rx_buf_full;
        logic line_quiet_flag;
        logic tx_busy;
        logic tx_pin_owned;
        logic rx_pin_owned;
        logic rx_standby;
    } spc2_status_s;

    typedef enum logic [1:0] {
        FRM_DATA,
        FRM_IDLE,
        FRM_BREAK
    } spc2_frame_e;

    typedef enum logic {
        TXS_IDLE,
        TXS_SHIFT
    } spc2_txstate_e;

endpackage : spc2_pkg

// [core/spc2_top.sv]
// Serial port second control register with transmit queueing, pin ownership and standby
//
// How it works
// RULE1 - Transmit-empty enable gates its flag to interrupt
// RULE2 - Transmit-done enable gates its flag to interrupt
// RULE3 - Receive-full enable gates its flag to interrupt
// RULE4 - Line-quiet enable gates its flag to interrupt
// RULE5 - Transmitter on drives and owns output pin
// RULE6 - Single-wire mode: direction bit steers the line
// RULE7 - Re-enabling transmitter mid-frame queues one idle
// RULE8 - Pin ownership held until queued traffic drains
// RULE9 - Receiver off releases the input pin
// RULE10 - Loopback releases input pin despite receiver on
// RULE11 - Standby bit parks receiver awaiting wakeup
// RULE12 - Wakeup is idle line or address mark
// RULE13 - Software sets standby, wakeup clears it
// RULE14 - Break bit one then zero queues break
// RULE15 - Break bit held keeps queuing break frames
// RULE16 - One or two breaks may follow a pulse
// RULE17 - Control register accessible at any moment
// RULE18 - Loopback feeds receiver from output line
// RULE19 - Nine-bit select adds a ninth data bit
// RULE20 - Enabled flags merge into one interrupt
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "spc2_params.svh"

module spc2_top #(
    parameter int BIT_CYCLES = `SPC2_BIT_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       rx_buf_full,
    input  wire logic       line_quiet_flag,
    input  wire logic       wake_idle_seen,
    input  wire logic       wake_mark_seen,
    input  wire logic       serial_out_pin_in,
    output logic            serial_out_pin_out,
    output logic            serial_out_pin_oe,
    output logic            rx_pin_owned,
    output logic            rx_line,
    output logic            rx_enabled,
    output logic            rx_standby,
    output logic            irq
);

    // The divider is 16 bits wide and needs at least one cycle per bit
    if (BIT_CYCLES < 1 || BIT_CYCLES > 65535) begin : g_bad_bit_cycles
        $error("BIT_CYCLES out of range");
    end

    function automatic logic hit(input logic [1:0] addr, input logic [1:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // Register and queue state
    spc2_pkg::spc2_ctrl_s ctrl;
    spc2_pkg::spc2_ctrl_s next_ctrl;
    spc2_pkg::spc2_cfg_s  cfg;
    spc2_pkg::spc2_cfg_s  next_cfg;
    logic [7:0]           tx_buf;
    logic [7:0]           next_tx_buf;
    logic                 tx_buf_full;
    logic                 next_tx_buf_full;
    logic                 idle_pend;
    logic                 next_idle_pend;
    logic                 brk_pend;
    logic                 next_brk_pend;

    // Transmitter interface
    logic                  tx_busy;
    logic                  tx_line;
    logic                  tx_start;
    spc2_pkg::spc2_frame_e tx_kind;
    logic                  tx_done;
    logic                  tx_owner;
    logic                  wr_ctrl;
    logic                  wake_hit;

    // Bit-time enable divider
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic        bit_tick;

    always_comb begin
        bit_tick     = (div_cnt == 16'h0000);
        next_div_cnt = bit_tick ? 16'(BIT_CYCLES - 1) : div_cnt - 16'h0001;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // Launch decision: idle, then break, then data
    always_comb begin
        tx_start = 1'b0;
        tx_kind  = spc2_pkg::FRM_DATA;
        if (!tx_busy) begin
            if (idle_pend) begin
                tx_start = 1'b1;
                tx_kind  = spc2_pkg::FRM_IDLE;  // [RULE7]
            end else if (brk_pend || ctrl.break_queue) begin
                tx_start = 1'b1;
                tx_kind  = spc2_pkg::FRM_BREAK;  // [RULE15] [RULE16]
            end else if (tx_buf_full) begin
                tx_start = 1'b1;
                tx_kind  = spc2_pkg::FRM_DATA;
            end
        end
    end

    // Traffic still owed keeps the transmitter in charge of the pin
    assign tx_owner = ctrl.tx_on | tx_busy | tx_start | idle_pend | brk_pend | tx_buf_full;  // [RULE8]
    assign tx_done  = !tx_buf_full && !tx_busy && !idle_pend && !brk_pend && !ctrl.break_queue;
    assign wr_ctrl  = reg_wr && hit(reg_addr, `SPC2_OFS_CTRL2);
    assign wake_hit = cfg.wake_sel ? wake_mark_seen : wake_idle_seen;  // [RULE12]

    always_comb begin
        next_ctrl        = ctrl;
        next_cfg         = cfg;
        next_tx_buf      = tx_buf;
        next_tx_buf_full = tx_buf_full;
        next_idle_pend   = idle_pend;
        next_brk_pend    = brk_pend;
        if (tx_start) begin
            case (tx_kind)
                spc2_pkg::FRM_IDLE:  next_idle_pend   = 1'b0;
                spc2_pkg::FRM_BREAK: next_brk_pend    = 1'b0;
                spc2_pkg::FRM_DATA:  next_tx_buf_full = 1'b0;
                default:             next_tx_buf_full = tx_buf_full;
            endcase
        end
        // Hardware clears standby on the chosen wakeup event
        if (ctrl.rx_standby && wake_hit) begin
            next_ctrl.rx_standby = 1'b0;  // [RULE13]
        end
        // Writes are taken whatever the transmitter or receiver is doing
        if (wr_ctrl) begin
            next_ctrl = spc2_pkg::spc2_ctrl_s'(reg_wdata);  // [RULE17] [RULE11] [RULE13]
            if (reg_wdata[`SPC2_BIT_TX_ON] && !ctrl.tx_on) begin
                next_idle_pend = 1'b1;  // [RULE7]
            end
            if (reg_wdata[`SPC2_BIT_BREAK_QUEUE] && !ctrl.break_queue) begin
                next_brk_pend = 1'b1;  // [RULE14]
            end
        end
        if (reg_wr && hit(reg_addr, `SPC2_OFS_CFG)) begin
            next_cfg = spc2_pkg::spc2_cfg_s'(reg_wdata);
        end
        if (reg_wr && hit(reg_addr, `SPC2_OFS_TXDATA)) begin
            next_tx_buf      = reg_wdata;
            next_tx_buf_full = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl        <= spc2_pkg::spc2_ctrl_s'(`SPC2_CTRL2_RESET);
            cfg         <= spc2_pkg::spc2_cfg_s'(`SPC2_CFG_RESET);
            tx_buf      <= 8'h00;
            tx_buf_full <= 1'b0;
            idle_pend   <= 1'b0;
            brk_pend    <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            cfg         <= next_cfg;
            tx_buf      <= next_tx_buf;
            tx_buf_full <= next_tx_buf_full;
            idle_pend   <= next_idle_pend;
            brk_pend    <= next_brk_pend;
        end
    end

    spc2_tx u_tx (
        .mclk           (mclk),
        .rstn           (rstn),
        .bit_tick       (bit_tick),
        .start          (tx_start),
        .kind           (tx_kind),
        .data           ({cfg.tx_bit8, tx_buf}),
        .nine_bit_sel   (cfg.nine_bit_sel),
        .long_break_sel (cfg.long_break_sel),
        .busy           (tx_busy),
        .line           (tx_line)
    );

    // Pins, interrupt and read data, all registered
    logic                   next_out;
    logic                   next_oe;
    logic                   next_rx_own;
    logic                   next_rx_line;
    logic                   next_irq;
    logic [7:0]             next_rdata;
    spc2_pkg::spc2_status_s stat;

    always_comb begin
        stat.tx_buf_empty    = !tx_buf_full;
        stat.tx_done         = tx_done;
        stat.rx_buf_full     = rx_buf_full;
        stat.line_quiet_flag = line_quiet_flag;
        stat.tx_busy         = tx_busy;
        stat.tx_pin_owned    = tx_owner;
        stat.rx_pin_owned    = ctrl.rx_on && !cfg.loopback_sel;
        stat.rx_standby      = ctrl.rx_standby;
        next_out = tx_line;
        next_oe  = tx_owner;  // [RULE5] [RULE8]
        if (cfg.loopback_sel && cfg.rx_source_sel) begin
            next_oe = tx_owner && cfg.single_line_dir;  // [RULE6]
        end
        next_rx_own  = ctrl.rx_on && !cfg.loopback_sel;  // [RULE9] [RULE10]
        next_rx_line = tx_line;  // [RULE18]
        if (cfg.loopback_sel && cfg.rx_source_sel && !next_oe) begin
            next_rx_line = serial_out_pin_in;  // [RULE6] [RULE18]
        end else if (!cfg.loopback_sel) begin
            next_rx_line = 1'b1;
        end
        next_irq = (ctrl.tx_empty_irq_en && stat.tx_buf_empty)         // [RULE1] [RULE20]
                || (ctrl.tx_done_irq_en && tx_done)                   // [RULE2]
                || (ctrl.rx_full_irq_en && rx_buf_full)               // [RULE3]
                || (ctrl.line_quiet_irq_en && line_quiet_flag);       // [RULE4]
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `SPC2_OFS_CTRL2:  next_rdata = ctrl;  // [RULE17]
                `SPC2_OFS_CFG:    next_rdata = cfg;
                `SPC2_OFS_STATUS: next_rdata = stat;
                `SPC2_OFS_TXDATA: next_rdata = tx_buf;
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            serial_out_pin_out <= 1'b1;
            serial_out_pin_oe  <= 1'b0;
            rx_pin_owned       <= 1'b0;
            rx_line            <= 1'b1;
            rx_enabled         <= 1'b0;
            rx_standby         <= 1'b0;
            irq                <= 1'b0;
            reg_rdata          <= 8'h00;
        end else begin
            serial_out_pin_out <= next_out;
            serial_out_pin_oe  <= next_oe;
            rx_pin_owned       <= next_rx_own;
            rx_line            <= next_rx_line;
            rx_enabled         <= ctrl.rx_on;
            rx_standby         <= ctrl.rx_standby;  // [RULE11]
            irq                <= next_irq;
            reg_rdata          <= next_rdata;
        end
    end

endmodule : spc2_top

`default_nettype wire

// [core/spc2_tx.sv]
// Transmit shifter that sends data, idle and break frames least significant bit first
`timescale 1ns/1ps
`default_nettype none
`include "spc2_params.svh"

module spc2_tx (
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic               bit_tick,
    input  wire logic               start,
    input  wire spc2_pkg::spc2_frame_e kind,
    input  wire logic [8:0]         data,
    input  wire logic               nine_bit_sel,
    input  wire logic               long_break_sel,
    output logic                    busy,
    output logic                    line
);

    spc2_pkg::spc2_txstate_e state;
    spc2_pkg::spc2_txstate_e next_state;
    logic [13:0]                     shreg;
    logic [13:0]                     next_shreg;
    logic [3:0]                      left;
    logic [3:0]                      next_left;

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_left  = left;
        case (state)
            spc2_pkg::TXS_IDLE: begin
                if (start) begin
                    next_state = spc2_pkg::TXS_SHIFT;
                    next_left  = nine_bit_sel ? `SPC2_LEN_SHORT9 : `SPC2_LEN_SHORT;  // [RULE19]
                    case (kind)
                        spc2_pkg::FRM_DATA: begin
                            // Start bit, 8 data bits, optional ninth bit, stop bit
                            if (nine_bit_sel) begin
                                next_shreg = {3'h7, data[8], data[7:0], 1'b0};  // [RULE19]
                            end else begin
                                next_shreg = {5'h1F, data[7:0], 1'b0};  // [RULE19]
                            end
                        end
                        spc2_pkg::FRM_IDLE: begin
                            next_shreg = 14'h3FFF;
                        end
                        spc2_pkg::FRM_BREAK: begin
                            next_shreg = 14'h0000;  // [RULE15]
                            if (long_break_sel) begin
                                next_left = nine_bit_sel ? `SPC2_LEN_LONG9 : `SPC2_LEN_LONG;  // [RULE15]
                            end
                        end
                        default: begin
                            next_shreg = 14'h3FFF;
                        end
                    endcase
                end
            end
            spc2_pkg::TXS_SHIFT: begin
                if (bit_tick) begin
                    next_shreg = {1'b1, shreg[13:1]};
                    next_left  = left - 4'h1;
                    if (left == 4'h1) begin
                        next_state = spc2_pkg::TXS_IDLE;
                        next_shreg = 14'h3FFF;
                    end
                end
            end
            default: begin
                next_state = spc2_pkg::TXS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= spc2_pkg::TXS_IDLE;
            shreg <= 14'h3FFF;
            left  <= 4'h0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            left  <= next_left;
        end
    end

    assign busy = (state == spc2_pkg::TXS_SHIFT);
    assign line = shreg[0];

endmodule : spc2_tx

`default_nettype wire
